// file: design/wlt_nv_mem.sv
// Nonvolatile word store with registered read data
`timescale 1ns/1ps
module wlt_nv_mem #(
  parameter int WORD_W = 16,
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Access port
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WORD_W-1:0] wr_data,
  output logic      [WORD_W-1:0] rd_data
);

  if (WORD_W < 1 || ADDR_W < 1)
  begin : g_bad_param
    $error("wlt_nv_mem: widths must be positive");
  end

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] next_rd_data;

  always_comb
  begin
    next_rd_data = rd_data;
    if (rd_en)
    begin
      next_rd_data = mem[addr];
    end
  end

  // Contents survive reset
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= next_rd_data;
    end
  end

endmodule : wlt_nv_mem

// file: design/wlt_pkg.sv
// Types for the wiper log-taper and nonvolatile map block
package wlt_pkg;

  typedef logic [9:0]  wlt_code_t;
  typedef logic [15:0] wlt_word_t;
  typedef logic [3:0]  wlt_addr_t;

  typedef enum logic [5:0]
  {
    S_BOOT  = 6'h01,
    S_IDLE  = 6'h02,
    S_LOAD1 = 6'h04,
    S_LOAD2 = 6'h08,
    S_WIPE1 = 6'h10,
    S_RDMEM = 6'h20
  } wlt_state_t;

endpackage : wlt_pkg

// file: design/wlt_regs.svh
// Constants for the wiper log-taper and nonvolatile map block
`ifndef WLT_REGS_SVH
`define WLT_REGS_SVH

// Nonvolatile address map
`define WLT_ADDR_WIPER       4'h0
`define WLT_ADDR_AUX         4'h1
`define WLT_ADDR_SPARE_FIRST 4'h2
`define WLT_ADDR_SPARE_LAST  4'hF
`define WLT_SPARE_COUNT      14
`define WLT_NV_ADDR_W        4
`define WLT_NV_WORD_W        16

// Opcodes
`define WLT_OP_NOP        4'h0
`define WLT_OP_RESTORE    4'h1
`define WLT_OP_STORE_WIPE 4'h2
`define WLT_OP_STORE_DATA 4'h3
`define WLT_OP_DOWN_6DB   4'h4
`define WLT_OP_DOWN_6DB_X 4'h5
`define WLT_OP_DEC        4'h6
`define WLT_OP_DEC_X      4'h7
`define WLT_OP_RESET      4'h8
`define WLT_OP_READ_MEM   4'h9
`define WLT_OP_READ_WIPE  4'hA
`define WLT_OP_WRITE_WIPE 4'hB
`define WLT_OP_UP_6DB     4'hC
`define WLT_OP_UP_6DB_X   4'hD
`define WLT_OP_INC        4'hE
`define WLT_OP_INC_X      4'hF

// Frame layout
`define WLT_FRAME_W    24
`define WLT_FRAME_BITS 5'h18
`define WLT_CMD_MSB    23
`define WLT_CMD_LSB    20
`define WLT_ADDR_MSB   19
`define WLT_ADDR_LSB   16
`define WLT_DATA_MSB   15

// Wiper codes and fields
`define WLT_WIPER_W    10
`define WLT_WIPER_MSB  9
`define WLT_TAPS       1024
`define WLT_WIPER_ZERO 10'h000
`define WLT_WIPER_ONE  10'h001
`define WLT_WIPER_MID  10'h200
`define WLT_WIPER_FULL 10'h3FF
`define WLT_WIPER_PAD  6'h00
`define WLT_AUX_A_BIT  0
`define WLT_AUX_B_BIT  1

`endif

// file: design/wlt_tap_decode.sv
// One-hot tap select decoder for the wiper code
`timescale 1ns/1ps
module wlt_tap_decode #(
  parameter int CODE_W = 10,
  parameter int TAPS   = 1024
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Code in, taps out
  input  wire logic [CODE_W-1:0] code,
  output logic      [TAPS-1:0]   tap_select
);

  if (TAPS != (1 << CODE_W))
  begin : g_bad_param
    $error("wlt_tap_decode: TAPS must equal 2**CODE_W");
  end

  for (genvar i = 0; i < TAPS; i++)
  begin : g_tap
    localparam logic RST_V = (i == 0);
    logic next_sel;

    always_comb
    begin
      next_sel = (code == CODE_W'(i));
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        tap_select[i] <= RST_V;
      end
      else
      begin
        tap_select[i] <= next_sel;
      end
    end
  end

endmodule : wlt_tap_decode

// file: design/wlt_top.sv
// Wiper code register, log-taper steps, nonvolatile map and serial frame
`timescale 1ns/1ps
`include "wlt_regs.svh"
module wlt_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Serial frame
  input  wire logic                cs_b,
  input  wire logic                sclk,
  input  wire logic                sdi,
  output logic                     sdo,
  output logic                     sdo_oe,
  // Preset restore strobe
  input  wire logic                preset_restore_pin_b,
  // Wiper and ladder
  output wlt_pkg::wlt_code_t       wiper_code_register,
  output logic [`WLT_TAPS-1:0]     tap_select,
  // Aux outputs and status
  output logic                     aux_output_bit_a,
  output logic                     aux_output_bit_b,
  output logic                     read_power_active,
  output logic                     busy
);
  import wlt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    sclk_q;
  logic                    cs_q;
  logic                    pr_q;
  logic [`WLT_FRAME_W-1:0] frame_sr;
  logic [4:0]              bit_cnt;
  logic                    next_sclk_q;
  logic                    next_cs_q;
  logic                    next_pr_q;
  logic [`WLT_FRAME_W-1:0] next_frame_sr;
  logic [4:0]              next_bit_cnt;

  wlt_state_t              state;
  wlt_state_t              next_state;
  wlt_code_t               next_wiper;
  logic [1:0]              aux;
  logic [1:0]              next_aux;
  logic                    next_rd_power;

  logic                    sclk_rise;
  logic                    cs_fall;
  logic                    cs_rise;
  logic                    pr_fall;
  logic                    frame_full;
  logic                    exec_go;
  logic [3:0]              frame_cmd;
  wlt_addr_t               frame_addr;
  wlt_word_t               frame_data;

  logic                    mem_we;
  logic                    mem_rd;
  wlt_addr_t               mem_addr;
  wlt_word_t               mem_wdata;
  wlt_word_t               mem_rdata;
  logic                    load_out;
  wlt_word_t               out_word;

  ////////////////////////////////////////////////////////////////////////////
  // Step functions

  function automatic wlt_code_t step_up(input wlt_code_t cur);
    wlt_code_t res;
    if (cur == `WLT_WIPER_ZERO)
    begin
      res = `WLT_WIPER_ONE;
    end
    else if (cur >= `WLT_WIPER_MID)
    begin
      res = `WLT_WIPER_FULL;
    end
    else
    begin
      res = {cur[`WLT_WIPER_MSB-1:0], 1'b0};
    end
    return res;
  endfunction : step_up

  function automatic wlt_code_t step_down(input wlt_code_t cur);
    // Zero stays zero, odd codes lose their low bit
    return {1'b0, cur[`WLT_WIPER_MSB:1]};
  endfunction : step_down

  function automatic wlt_code_t lin_up(input wlt_code_t cur);
    return (cur == `WLT_WIPER_FULL) ? cur : cur + `WLT_WIPER_ONE;
  endfunction : lin_up

  function automatic wlt_code_t lin_down(input wlt_code_t cur);
    return (cur == `WLT_WIPER_ZERO) ? cur : cur - `WLT_WIPER_ONE;
  endfunction : lin_down

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture

  assign sclk_rise  = sclk & ~sclk_q;
  assign cs_fall    = cs_q & ~cs_b;
  assign cs_rise    = cs_b & ~cs_q;
  assign pr_fall    = pr_q & ~preset_restore_pin_b;
  assign frame_full = (bit_cnt == `WLT_FRAME_BITS);
  assign exec_go    = cs_rise & frame_full & (state == S_IDLE);
  assign frame_cmd  = frame_sr[`WLT_CMD_MSB:`WLT_CMD_LSB];
  assign frame_addr = frame_sr[`WLT_ADDR_MSB:`WLT_ADDR_LSB];
  assign frame_data = frame_sr[`WLT_DATA_MSB:0];

  always_comb
  begin
    next_sclk_q   = sclk;
    next_cs_q     = cs_b;
    next_pr_q     = preset_restore_pin_b;
    next_frame_sr = frame_sr;
    next_bit_cnt  = bit_cnt;
    if (cs_fall)
    begin
      next_bit_cnt = 5'h00;
    end
    if (!cs_b && sclk_rise)
    begin
      next_frame_sr = {frame_sr[`WLT_FRAME_W-2:0], sdi};
      if (!frame_full)
      begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
    end
    // Read answer replaces the data bytes for the next frame
    if (load_out)
    begin
      next_frame_sr[`WLT_DATA_MSB:0] = out_word;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      pr_q     <= 1'b1;
      frame_sr <= '0;
      bit_cnt  <= 5'h00;
    end
    else
    begin
      sclk_q   <= next_sclk_q;
      cs_q     <= next_cs_q;
      pr_q     <= next_pr_q;
      frame_sr <= next_frame_sr;
      bit_cnt  <= next_bit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution and reload sequencing

  always_comb
  begin
    next_state    = state;
    next_wiper    = wiper_code_register;
    next_aux      = aux;
    next_rd_power = read_power_active;
    mem_we        = 1'b0;
    mem_rd        = 1'b0;
    mem_addr      = `WLT_ADDR_WIPER;
    mem_wdata     = frame_data;
    load_out      = 1'b0;
    out_word      = frame_data;
    unique case (state)
      S_BOOT:
      begin
        mem_rd     = 1'b1;
        next_state = S_LOAD1;
      end
      S_LOAD1:
      begin
        next_wiper = mem_rdata[`WLT_WIPER_MSB:0];
        mem_rd     = 1'b1;
        mem_addr   = `WLT_ADDR_AUX;
        next_state = S_LOAD2;
      end
      S_LOAD2:
      begin
        next_aux   = {mem_rdata[`WLT_AUX_B_BIT], mem_rdata[`WLT_AUX_A_BIT]};
        next_state = S_IDLE;
      end
      S_WIPE1:
      begin
        next_wiper = mem_rdata[`WLT_WIPER_MSB:0];
        next_state = S_IDLE;
      end
      S_RDMEM:
      begin
        load_out   = 1'b1;
        out_word   = mem_rdata;
        next_state = S_IDLE;
      end
      S_IDLE:
      begin
        if (exec_go)
        begin
          case (frame_cmd)
            `WLT_OP_NOP:
            begin
              next_rd_power = 1'b0;
            end
            `WLT_OP_RESTORE, `WLT_OP_RESET:
            begin
              mem_rd     = 1'b1;
              next_state = S_LOAD1;
              if (frame_cmd == `WLT_OP_RESTORE)
              begin
                next_rd_power = 1'b1;
              end
            end
            `WLT_OP_STORE_WIPE:
            begin
              mem_we    = 1'b1;
              mem_wdata = {`WLT_WIPER_PAD, wiper_code_register};
            end
            `WLT_OP_STORE_DATA:
            begin
              mem_we   = 1'b1;
              mem_addr = frame_addr;
            end
            `WLT_OP_DOWN_6DB, `WLT_OP_DOWN_6DB_X:
            begin
              next_wiper = step_down(wiper_code_register);
            end
            `WLT_OP_DEC, `WLT_OP_DEC_X:
            begin
              next_wiper = lin_down(wiper_code_register);
            end
            `WLT_OP_READ_MEM:
            begin
              mem_rd        = 1'b1;
              mem_addr      = frame_addr;
              next_rd_power = 1'b1;
              next_state    = S_RDMEM;
            end
            `WLT_OP_READ_WIPE:
            begin
              load_out = 1'b1;
              out_word = {`WLT_WIPER_PAD, wiper_code_register};
            end
            `WLT_OP_WRITE_WIPE:
            begin
              next_wiper = frame_data[`WLT_WIPER_MSB:0];
            end
            `WLT_OP_UP_6DB, `WLT_OP_UP_6DB_X:
            begin
              next_wiper = step_up(wiper_code_register);
            end
            `WLT_OP_INC, `WLT_OP_INC_X:
            begin
              next_wiper = lin_up(wiper_code_register);
            end
          endcase
        end
        else if (pr_fall)
        begin
          mem_rd     = 1'b1;
          next_state = S_WIPE1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state               <= S_BOOT;
      wiper_code_register <= `WLT_WIPER_ZERO;
      aux                 <= 2'h0;
      read_power_active   <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      wiper_code_register <= next_wiper;
      aux                 <= next_aux;
      read_power_active   <= next_rd_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sdo              = frame_sr[`WLT_CMD_MSB];
  assign sdo_oe           = ~cs_b;
  assign aux_output_bit_a = aux[0];
  assign aux_output_bit_b = aux[1];
  assign busy             = (state != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Store and tap decoder

  wlt_nv_mem #(
    .WORD_W (`WLT_NV_WORD_W),
    .ADDR_W (`WLT_NV_ADDR_W)
  ) u_nv_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (mem_we),
    .rd_en   (mem_rd),
    .addr    (mem_addr),
    .wr_data (mem_wdata),
    .rd_data (mem_rdata)
  );

  wlt_tap_decode #(
    .CODE_W (`WLT_WIPER_W),
    .TAPS   (`WLT_TAPS)
  ) u_tap_decode (
    .clk        (clk),
    .rst_b      (rst_b),
    .code       (wiper_code_register),
    .tap_select (tap_select)
  );

endmodule : wlt_top

// file: dv/wlt_host.sv
// Serial host model sending frames and capturing the word shifted out
`timescale 1ns/1ps
module wlt_host (
  // Clock
  input  wire logic clk,
  // Serial frame
  output logic      cs_b,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial
  begin
    cs_b = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // Released data line toggles so a stale bit is never mistaken
  always @(posedge clk)
    if (cs_b)
      sdi <= ~sdi;
  // MSB first, sclk phases of two or more clocks, idle gap after select
  task automatic send(input logic [23:0] f, input int n, output logic [23:0] rx);
    int slow;
    slow = $urandom_range(2);
    rx = 24'h000000;
    cs_b <= 1'b0;
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi <= f[i];
      repeat (2 + slow) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[22:0], sdo};
      repeat (2 + slow) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cs_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : send
endmodule : wlt_host

// file: dv/wlt_top_bench.sv
// Self-checking bench for wiper steps, reloads and the stored word map
`timescale 1ns/1ps
`include "wlt_regs.svh"
module wlt_top_bench;
  import wlt_pkg::*;
  logic        clk, rst_b, cs_b, sclk, sdi, sdo, pr_b, aux_a, aux_b, rpa, busy;
  logic [23:0] rx;
  logic [3:0]  op;
  wlt_code_t   wiper, exp;
  wlt_word_t   mem [16];
  int          err_total, n_compared;
  logic [3:0]  step_ops [4] = '{`WLT_OP_UP_6DB, `WLT_OP_UP_6DB_X, `WLT_OP_DOWN_6DB,
                                `WLT_OP_DOWN_6DB_X};
  wlt_code_t   corners [4] = '{10'h1FF, 10'h200, 10'h3FF, 10'h001};
  initial
    clk = 1'b0;
  always #10 clk = ~clk;
  wlt_top dut_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(), .preset_restore_pin_b(pr_b), .wiper_code_register(wiper),
    .tap_select(), .aux_output_bit_a(aux_a), .aux_output_bit_b(aux_b),
    .read_power_active(rpa), .busy(busy));
  wlt_host host_u (.clk(clk), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
    n_compared++;
    if (seen !== want)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic [3:0] op_i, input logic [3:0] a_i, input wlt_word_t d_i);
    host_u.send({op_i, a_i, d_i}, 24, rx);
  endtask : cmd
  // Expected code after one taper step
  function automatic wlt_code_t f_step(input logic [3:0] o, input wlt_code_t c);
    if (o == `WLT_OP_DOWN_6DB || o == `WLT_OP_DOWN_6DB_X)
      return c >> 1;
    if (c == 10'h000)
      return 10'h001;
    if (c >= 10'h200)
      return 10'h3FF;
    return c << 1;
  endfunction : f_step
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h8339B1ED));
    err_total  = 0;
    n_compared = 0;
    rst_b      = 1'b0;
    pr_b       = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    for (int a = 0; a < 16; a++)
    begin
      mem[a] = 16'($urandom);
      cmd(`WLT_OP_STORE_DATA, a[3:0], mem[a]);
    end
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    check("wiper", wiper, mem[0][9:0]);
    check("aux", {aux_b, aux_a}, mem[1][1:0]);
    for (int a = 0; a < 16; a++)
    begin
      cmd(`WLT_OP_READ_MEM, a[3:0], 16'($urandom));
      cmd(`WLT_OP_NOP, 4'h0, 16'h0000);
      check("read", rx, {`WLT_OP_READ_MEM, a[3:0], mem[a]});
    end
    // Up from zero past full scale, then down past zero
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h0000);
    exp = 10'h000;
    for (int i = 0; i < 26; i++)
    begin
      op  = (i < 13) ? step_ops[i % 2] : step_ops[2 + i % 2];
      cmd(op, op[0] ? 4'($urandom) : 4'h0, 16'($urandom));
      exp = f_step(op, exp);
      check("walk", wiper, exp);
    end
    for (int i = 0; i < 40; i++)
    begin
      exp = (i < 4) ? corners[i] : 10'($urandom);
      op  = step_ops[(i < 4) ? i : $urandom_range(3)];
      cmd(`WLT_OP_WRITE_WIPE, 4'h0, {6'h00, exp});
      cmd(op, 4'h0, 16'($urandom));
      exp = f_step(op, exp);
      check("step", wiper, exp);
    end
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h0155);
    cmd(`WLT_OP_RESTORE, 4'h0, 16'($urandom));
    check("restore", {rpa, wiper}, {1'b1, mem[0][9:0]});
    cmd(`WLT_OP_NOP, 4'($urandom), 16'($urandom));
    check("idle", {rpa, wiper}, {1'b0, mem[0][9:0]});
    mem[1] = ~mem[1];
    cmd(`WLT_OP_STORE_DATA, 4'h1, mem[1]);
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h02AA);
    cmd(`WLT_OP_RESET, 4'($urandom), 16'($urandom));
    check("reset", {aux_b, aux_a, wiper}, {mem[1][1:0], mem[0][9:0]});
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h0005);
    pr_b <= 1'b0;
    repeat (3) @(posedge clk);
    pr_b <= 1'b1;
    repeat (4) @(posedge clk);
    check("preset", wiper, mem[0][9:0]);
    host_u.send({`WLT_OP_WRITE_WIPE, 4'h0, 16'h0123}, 16, rx);
    check("short", wiper, mem[0][9:0]);
    cmd(`WLT_OP_READ_WIPE, 4'h0, 16'h0000);
    cmd(`WLT_OP_NOP, 4'h0, 16'h0000);
    check("wiper read", rx, {`WLT_OP_READ_WIPE, 4'h0, 6'h00, mem[0][9:0]});
    // Linear steps, their saturation, and storing the wiper word
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h03FD);
    cmd(`WLT_OP_INC, 4'h0, 16'($urandom));
    check("inc", wiper, 10'h3FE);
    cmd(`WLT_OP_INC_X, 4'($urandom), 16'($urandom));
    check("inc x", wiper, 10'h3FF);
    cmd(`WLT_OP_INC, 4'h0, 16'($urandom));
    check("inc top", wiper, 10'h3FF);
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h0002);
    cmd(`WLT_OP_DEC, 4'h0, 16'($urandom));
    check("dec", wiper, 10'h001);
    cmd(`WLT_OP_DEC_X, 4'($urandom), 16'($urandom));
    check("dec x", wiper, 10'h000);
    cmd(`WLT_OP_DEC, 4'h0, 16'($urandom));
    check("dec bottom", wiper, 10'h000);
    cmd(`WLT_OP_WRITE_WIPE, 4'h0, 16'h02C3);
    cmd(`WLT_OP_STORE_WIPE, 4'h0, 16'($urandom));
    cmd(`WLT_OP_READ_MEM, 4'h0, 16'h0000);
    cmd(`WLT_OP_NOP, 4'h0, 16'h0000);
    check("stored wiper", rx, {`WLT_OP_READ_MEM, 4'h0, 16'h02C3});
    tally_and_finish();
  end
endmodule : wlt_top_bench

// file: dv/wlt_top_chk.sv
// Concurrent checks on wiper steps, reloads, frame timing and tap select
`timescale 1ns/1ps
`include "wlt_regs.svh"
module wlt_top_chk (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // Serial frame and preset pin
  input wire logic                 cs_b,
  input wire logic                 sclk,
  input wire logic                 sdi,
  input wire logic                 preset_restore_pin_b,
  // Watched outputs
  input wire wlt_pkg::wlt_code_t   wiper_code_register,
  input wire logic [`WLT_TAPS-1:0] tap_select,
  input wire logic                 read_power_active,
  input wire logic                 busy,
  input wire logic                 sdo_oe
);
  import wlt_pkg::*;
  logic        sclk_q, cs_q, armed, next_armed, tk;
  logic [4:0]  cnt, next_cnt;
  logic [23:0] sr, next_sr;
  logic [3:0]  op;
  assign op = sr[`WLT_CMD_MSB:`WLT_CMD_LSB];
  assign tk = !cs_q && cs_b && cnt == `WLT_FRAME_BITS && !busy;
  ////////////////////////////////////////////////////////////
  // Shadow of the serial frame; armed once a known code is written
  always_comb
  begin
    next_sr    = sr;
    next_cnt   = cs_b ? 5'h00 : cnt;
    next_armed = armed | (tk && op == `WLT_OP_WRITE_WIPE);
    if (!cs_b && sclk && !sclk_q)
    begin
      next_sr  = {sr[22:0], sdi};
      next_cnt = (cnt == `WLT_FRAME_BITS) ? cnt : cnt + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      cnt    <= 5'h00;
      sr     <= 24'h000000;
      armed  <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q   <= cs_b;
      cnt    <= next_cnt;
      sr     <= next_sr;
      armed  <= next_armed;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_up;
    tk && (op == `WLT_OP_UP_6DB || op == `WLT_OP_UP_6DB_X);
  endsequence
  sequence s_down;
    tk && (op == `WLT_OP_DOWN_6DB || op == `WLT_OP_DOWN_6DB_X);
  endsequence
  sequence s_reload;
    busy ##2 !busy;
  endsequence
  property p_up_double;
    s_up ##0 wiper_code_register inside {[10'h001:10'h1FF]}
      |=> wiper_code_register == $past(wiper_code_register) << 1;
  endproperty
  property p_up_full;
    s_up ##0 wiper_code_register >= 10'h200 |=> wiper_code_register == 10'h3FF;
  endproperty
  property p_up_zero;
    s_up ##0 wiper_code_register == 10'h000 |=> wiper_code_register == 10'h001;
  endproperty
  property p_down_half;
    s_down |=> wiper_code_register == $past(wiper_code_register) >> 1;
  endproperty
  property p_nop_idle;
    tk && op == `WLT_OP_NOP |=> $stable(wiper_code_register) && !read_power_active;
  endproperty
  property p_restore_power;
    tk && op == `WLT_OP_RESTORE |=> read_power_active [*3];
  endproperty
  property p_reload_seq;
    tk && (op == `WLT_OP_RESTORE || op == `WLT_OP_RESET) |=> s_reload;
  endproperty
  property p_hold_frame;
    armed && !cs_b && !busy && preset_restore_pin_b && $past(preset_restore_pin_b)
      |=> $stable(wiper_code_register);
  endproperty
  property p_one_hot;
    armed |-> $onehot(tap_select);
  endproperty
  property p_tap_follow;
    armed |-> tap_select[$past(wiper_code_register)];
  endproperty
  // Serial output driven only while the frame is selected
  property p_sdo_drive;
    sdo_oe == !cs_b;
  endproperty
  a_up_double: assert property (p_up_double) else $error("No doubling");
  a_up_full: assert property (p_up_full) else $error("No full scale");
  a_up_zero: assert property (p_up_zero) else $error("Zero not to one");
  a_down_half: assert property (p_down_half) else $error("No halving");
  a_nop_idle: assert property (p_nop_idle) else $error("No-op changed state");
  a_restore_power: assert property (p_restore_power) else $error("Power state");
  a_reload_seq: assert property (p_reload_seq) else $error("Reload timing");
  a_hold_frame: assert property (p_hold_frame) else $error("Moved in frame");
  a_one_hot: assert property (p_one_hot) else $error("Tap not one-hot");
  a_tap_follow: assert property (p_tap_follow) else $error("Wrong tap");
  a_sdo_drive: assert property (p_sdo_drive) else $error("Output enable wrong");
endmodule : wlt_top_chk

bind wlt_top wlt_top_chk chk_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
  .sdi(sdi), .preset_restore_pin_b(preset_restore_pin_b),
  .wiper_code_register(wiper_code_register), .tap_select(tap_select),
  .read_power_active(read_power_active), .busy(busy), .sdo_oe(sdo_oe));
